// File: logic/lpm_params.svh
// Constants for the low-power mode controller: register offsets, fields, resets.
// Assumes inclusion by the package and the modules that need these macros.
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH
`define LPM_OFF_CTRL 4'h0
`define LPM_OFF_PRIO 4'h4
`define LPM_OFF_PORT 4'h8
`define LPM_OFF_STAT 4'hc
`define LPM_CTRL_HALT 0
`define LPM_CTRL_STOP 1
`define LPM_CTRL_MODE_LO 2
`define LPM_CTRL_MODE_HI 3
`define LPM_NUM_SRC 4
`define LPM_PRIO_W 3
`define LPM_PIN_W 8
`define LPM_PRIO_RST 12'h000
`define LPM_ERR_SLVERR 2'h2
`define LPM_OKAY 2'h0
`endif

// File: logic/lpm_pkg.sv
// Types shared by the low-power mode controller.
// Assumes lpm_params.svh on the include path.
`include "lpm_params.svh"
package lpm_pkg;
	typedef enum logic [1:0] {LPM_SINGLE, LPM_EXPAND, LPM_MICRO, LPM_RSVD} lpm_mode_e;
	typedef enum {LPM_RUN, LPM_HALT, LPM_STOP} lpm_state_e;
endpackage : lpm_pkg

// File: logic/lpm_wake.sv
// Wake detector: a pending request with nonzero priority, or the NMI, ends low power.
// Assumes synchronous request inputs and the priority bank of the controller.
`timescale 1ns/100ps
`include "lpm_params.svh"
module lpm_wake
	import lpm_pkg::*;
(
	input wire logic [`LPM_NUM_SRC-1:0] req, // Interrupt requests
	input wire logic [`LPM_NUM_SRC*`LPM_PRIO_W-1:0] prio, // Priority levels
	input wire logic nmi, // Non-maskable request
	output logic wake // Wake condition
);
	logic [`LPM_NUM_SRC-1:0] hit;
	genvar i;
	// A zero priority level disables its source
	generate
		for (i = 0; i < `LPM_NUM_SRC; i++)
		begin : g_src
			assign hit[i] = req[i] && (prio[i*`LPM_PRIO_W +: `LPM_PRIO_W] != '0);
		end
	endgenerate
	assign wake = nmi || (|hit);
endmodule : lpm_wake

// File: logic/lpm_ctrl.sv
// Low-power mode controller with AXI4-Lite registers and bus-pin hold.
// Assumes one 20 MHz clock, synchronous inputs, synchronous active-low reset.
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "lpm_params.svh"
module lpm_ctrl
	import lpm_pkg::*;
(
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, low active
	input wire logic [3:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [3:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic halt_insn, // CPU halt instruction pulse
	input wire logic [`LPM_NUM_SRC-1:0] irq_req, // Interrupt requests
	input wire logic nmi_req, // Non-maskable request
	input wire logic [`LPM_PIN_W-1:0] bus_out, // Bus data from the bus unit
	input wire logic [`LPM_PIN_W-1:0] bus_oe, // Bus enables from the bus unit
	output logic [`LPM_PIN_W-1:0] pin_o, // Pin output levels
	output logic [`LPM_PIN_W-1:0] pin_oe, // Pin output enables
	output logic cpu_halted, // CPU clock gated
	output logic clk_stopped // All clocks stopped
);
	localparam int PW = `LPM_NUM_SRC * `LPM_PRIO_W;
	lpm_state_e st_q, st_d;
	lpm_mode_e mode_q, mode_d;
	logic [PW-1:0] prio_q, prio_d;
	logic [`LPM_PIN_W-1:0] port_q, port_d, dir_q, dir_d;
	logic [`LPM_PIN_W-1:0] pin_o_q, pin_o_d, pin_oe_q, pin_oe_d;
	logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
	logic [3:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [3:0] ws_q, ws_d;
	logic [1:0] br_q, br_d, rr_q, rr_d;
	logic wake;
	logic do_wr;

	// Wake decode across all sources
	lpm_wake u_wake (
		.req(irq_req),
		.prio(prio_q),
		.nmi(nmi_req),
		.wake(wake)
	);

	// Bus mode test, used by pin mux and register writes
	function automatic logic is_bus(input lpm_mode_e m);
		is_bus = (m == LPM_EXPAND) || (m == LPM_MICRO);
	endfunction : is_bus

	// Byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (st[b])
			begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		merge = r;
	endfunction : merge

	assign do_wr = aw_q && w_q && !bv_q;

	// AXI write channel and register updates
	always_comb
	begin
		logic [31:0] v;
		v = '0;
		aw_d = aw_q;
		w_d = w_q;
		awa_d = awa_q;
		wd_d = wd_q;
		ws_d = ws_q;
		bv_d = bv_q;
		br_d = br_q;
		mode_d = mode_q;
		prio_d = prio_q;
		port_d = port_q;
		dir_d = dir_q;
		st_d = st_q;
		if (s_axi_awvalid && !aw_q)
		begin
			aw_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_q)
		begin
			w_d = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		if (bv_q && s_axi_bready)
		begin
			bv_d = 1'b0;
		end
		// Low-power state: leave only on an accepted wake request
		unique case (st_q)
			LPM_RUN:
			begin
				if (halt_insn)
				begin
					st_d = LPM_HALT;
				end
			end
			LPM_HALT, LPM_STOP:
			begin
				if (wake)
				begin
					st_d = LPM_RUN;
				end
			end
		endcase
		if (do_wr)
		begin
			aw_d = 1'b0;
			w_d = 1'b0;
			bv_d = 1'b1;
			br_d = `LPM_OKAY;
			unique case (awa_q)
				`LPM_OFF_CTRL:
				begin
					v = merge({28'h0, mode_q, 2'b00}, wd_q, ws_q);
					mode_d = lpm_mode_e'(v[`LPM_CTRL_MODE_HI:`LPM_CTRL_MODE_LO]);
					if (st_q == LPM_RUN && v[`LPM_CTRL_STOP])
					begin
						st_d = LPM_STOP;
					end
					else if (st_q == LPM_RUN && v[`LPM_CTRL_HALT])
					begin
						st_d = LPM_HALT;
					end
				end
				`LPM_OFF_PRIO:
				begin
					v = merge({20'h0, prio_q}, wd_q, ws_q);
					prio_d = v[PW-1:0];
				end
				`LPM_OFF_PORT:
				begin
					// Port writes are dropped while the pins serve the bus
					if (!is_bus(mode_q))
					begin
						v = merge({16'h0, dir_q, port_q}, wd_q, ws_q);
						port_d = v[7:0];
						dir_d = v[15:8];
					end
				end
				`LPM_OFF_STAT:
				begin
					v = '0;
				end
				default:
				begin
					br_d = `LPM_ERR_SLVERR;
				end
			endcase
		end
	end

	// AXI read channel
	always_comb
	begin
		rv_d = rv_q;
		rd_d = rd_q;
		rr_d = rr_q;
		if (rv_q && s_axi_rready)
		begin
			rv_d = 1'b0;
		end
		if (s_axi_arvalid && !rv_q)
		begin
			rv_d = 1'b1;
			rr_d = `LPM_OKAY;
			unique case (s_axi_araddr)
				`LPM_OFF_CTRL: rd_d = {28'h0, mode_q, 2'b00};
				`LPM_OFF_PRIO: rd_d = {20'h0, prio_q};
				`LPM_OFF_PORT: rd_d = {16'h0, dir_q, port_q};
				`LPM_OFF_STAT: rd_d = {30'h0, st_q == LPM_STOP, st_q == LPM_HALT};
				default:
				begin
					rd_d = '0;
					rr_d = `LPM_ERR_SLVERR;
				end
			endcase
		end
	end

	// Pin mux: bus modes hold in low power, single-chip drives the port
	always_comb
	begin
		pin_o_d = pin_o_q;
		pin_oe_d = pin_oe_q;
		if (!is_bus(mode_q))
		begin
			pin_o_d = port_q;
			pin_oe_d = dir_q;
		end
		else if (st_q == LPM_RUN)
		begin
			pin_o_d = bus_out;
			pin_oe_d = bus_oe;
		end
		// Halt and stop both keep the last bus level here
	end

	// State registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_q <= LPM_RUN;
			mode_q <= LPM_SINGLE;
			prio_q <= `LPM_PRIO_RST;
			port_q <= '0;
			dir_q <= '0;
			pin_o_q <= '0;
			pin_oe_q <= '0;
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= '0;
			wd_q <= '0;
			ws_q <= '0;
			bv_q <= 1'b0;
			br_q <= '0;
			rv_q <= 1'b0;
			rd_q <= '0;
			rr_q <= '0;
		end
		else
		begin
			st_q <= st_d;
			mode_q <= mode_d;
			prio_q <= prio_d;
			port_q <= port_d;
			dir_q <= dir_d;
			pin_o_q <= pin_o_d;
			pin_oe_q <= pin_oe_d;
			aw_q <= aw_d;
			w_q <= w_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			ws_q <= ws_d;
			bv_q <= bv_d;
			br_q <= br_d;
			rv_q <= rv_d;
			rd_q <= rd_d;
			rr_q <= rr_d;
		end
	end

	// Outputs straight from flip-flops, cpu_halted and clk_stopped decoded from st_q (ready flags are inverted holding flops)
	assign s_axi_awready = !aw_q;
	assign s_axi_wready = !w_q;
	assign s_axi_bvalid = bv_q;
	assign s_axi_bresp = br_q;
	assign s_axi_arready = !rv_q;
	assign s_axi_rvalid = rv_q;
	assign s_axi_rdata = rd_q;
	assign s_axi_rresp = rr_q;
	assign pin_o = pin_o_q;
	assign pin_oe = pin_oe_q;
	assign cpu_halted = (st_q != LPM_RUN);
	assign clk_stopped = (st_q == LPM_STOP);
endmodule : lpm_ctrl

// File: testbench/lpm_bus_dev.sv
// Stand-in for the bus unit that feeds the pin multiplexer.
// Assumes one clock; the bus levels change every cycle, the enables stay on.
`timescale 1ns/100ps
module lpm_bus_dev (
	input wire logic aclk, // Clock
	output logic [7:0] bus_out, // Bus levels
	output logic [7:0] bus_oe // Bus enables
);
	// Count, so that a pin stuck on an old level shows up
	always @(posedge aclk)
		bus_out <= (bus_out === 8'hxx) ? 8'h00 : bus_out + 8'h01;
	assign bus_oe = 8'hff;
endmodule : lpm_bus_dev

// File: testbench/lpm_ctrl_sva.sv
// Checker for lpm_ctrl: wake, pin hold and read answer.
// Assumes it is bound to lpm_ctrl, one clock domain.
`timescale 1ns/100ps
module lpm_ctrl_chk (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, low active
	input wire logic s_axi_arvalid, // Read address valid
	input wire logic s_axi_arready, // Read address ready
	input wire logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic [3:0] irq_req, // Requests
	input wire logic nmi_req, // Non-maskable request
	input wire logic [7:0] pin_o, // Pin levels
	input wire logic [7:0] pin_oe, // Pin enables
	input wire logic cpu_halted, // Halted
	input wire logic clk_stopped // Stopped
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Two halted cycles in a row
	sequence s_halted2;
		cpu_halted ##1 cpu_halted;
	endsequence
	// Two stopped cycles in a row
	sequence s_stopped2;
		clk_stopped ##1 clk_stopped;
	endsequence
	// Low-power states, wake and pins
	chk_halt_keep: assert property (cpu_halted && !nmi_req && irq_req == 4'h0 |=> cpu_halted)
		else $error("halt left with no request");
	chk_stop_keep: assert property (clk_stopped && !nmi_req && irq_req == 4'h0 |=> clk_stopped)
		else $error("stop left with no request");
	chk_nmi_wake: assert property (cpu_halted && nmi_req |=> !cpu_halted)
		else $error("non-maskable request did not wake");
	chk_pin_hold: assert property (s_halted2 |-> $stable(pin_o) && $stable(pin_oe))
		else $error("bus pins moved in low power");
	chk_stop_hold: assert property (s_stopped2 |-> $stable(pin_o) && $stable(pin_oe))
		else $error("bus pins moved in stop");
	chk_stop_halts: assert property (clk_stopped |-> cpu_halted)
		else $error("stop without halt");
	// Read handshake
	chk_read_ans: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
endmodule : lpm_ctrl_chk
bind lpm_ctrl lpm_ctrl_chk u_lpm_ctrl_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .irq_req, .nmi_req, .pin_o, .pin_oe, .cpu_halted, .clk_stopped);

// File: testbench/lpm_ctrl_tb_top.sv
// Testbench for lpm_ctrl: registers, low-power entry, wake, pin hold.
// Assumes lpm_params.svh on the include path.
`timescale 1ns/100ps
`include "lpm_params.svh"
module lpm_ctrl_tb_top;
	logic aclk = 0, aresetn = 0, halt_insn = 0, nmi_req = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, irq_req = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic cpu_halted, clk_stopped;
	logic [7:0] bus_out, bus_oe, pin_o, pin_oe, held;
	int failures = 0, n_checks = 0, cyc = 0;
	always #25 aclk = ~aclk;
	lpm_ctrl u_lpm_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .halt_insn, .irq_req,
		.nmi_req, .bus_out, .bus_oe, .pin_o, .pin_oe, .cpu_halted, .clk_stopped);
	lpm_bus_dev u_lpm_bus_dev (.aclk, .bus_out, .bus_oe);
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			failures++;
		end
	endtask : chk
	task automatic w(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask : w
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(`LPM_OKAY));
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, exp);
		chk(32'(s_axi_rresp), 32'(er));
	endtask : rd
	// Cut a hang short
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			failures++;
			end_sim();
		end
	end
	// Main sequence
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`LPM_OFF_PRIO, 32'h0, `LPM_OKAY);
		rd(4'h2, 32'h0, `LPM_ERR_SLVERR);
		wr(`LPM_OFF_PORT, 32'hff5a);
		w(2);
		chk(32'({pin_oe, pin_o}), 32'hff5a);
		$display("test single-chip done");
		wr(`LPM_OFF_CTRL, 32'h4);
		wr(`LPM_OFF_PORT, 32'h0011);
		w(2);
		chk(32'({pin_oe, pin_o}), {16'h0, bus_oe, bus_out - 8'h01});
		rd(`LPM_OFF_PORT, 32'hff5a, `LPM_OKAY);
		wr(`LPM_OFF_PRIO, 32'h18);
		@(posedge aclk);
		halt_insn <= 1'b1;
		@(posedge aclk);
		halt_insn <= 1'b0;
		w(2);
		held = pin_o;
		w(4);
		chk(32'({cpu_halted, pin_o}), {23'h0, 1'b1, held});
		@(posedge aclk);
		irq_req <= 4'h1;
		w(3);
		chk(32'(cpu_halted), 32'h1);
		@(posedge aclk);
		irq_req <= 4'h3;
		w(2);
		chk(32'(cpu_halted), 32'h0);
		@(posedge aclk);
		irq_req <= 4'h0;
		$display("test halt done");
		wr(`LPM_OFF_PRIO, 32'h0);
		wr(`LPM_OFF_CTRL, 32'h6);
		w(2);
		held = pin_o;
		w(4);
		chk(32'({clk_stopped, pin_o}), {23'h0, 1'b1, held});
		rd(`LPM_OFF_STAT, 32'h2, `LPM_OKAY);
		@(posedge aclk);
		irq_req <= 4'h2;
		w(3);
		chk(32'({clk_stopped, pin_o}), {23'h0, 1'b1, held});
		@(posedge aclk);
		irq_req <= 4'h0;
		nmi_req <= 1'b1;
		w(2);
		chk(32'(clk_stopped), 32'h0);
		@(posedge aclk);
		nmi_req <= 1'b0;
		$display("test stop done");
		wr(`LPM_OFF_CTRL, 32'h0);
		wr(`LPM_OFF_PORT, 32'h0f3c);
		w(2);
		chk(32'({pin_oe, pin_o}), 32'h0f3c);
		wr(`LPM_OFF_CTRL, 32'hc);
		w(2);
		chk(32'({pin_oe, pin_o}), 32'h0f3c);
		wr(`LPM_OFF_CTRL, 32'h1);
		w(2);
		chk(32'({cpu_halted, clk_stopped, pin_oe, pin_o}), 32'h20f3c);
		rd(`LPM_OFF_STAT, 32'h1, `LPM_OKAY);
		@(posedge aclk);
		nmi_req <= 1'b1;
		w(2);
		chk(32'(cpu_halted), 32'h0);
		@(posedge aclk);
		nmi_req <= 1'b0;
		$display("test return done");
		end_sim();
	end
endmodule : lpm_ctrl_tb_top
